// [shared/imfl_pkg.sv]
// Constants for the interrupt mask and queue level threshold block.
package imfl_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0]  OFF_STATUS      = 8'h58;
  localparam logic [7:0]  OFF_ENABLE      = 8'h5C;
  localparam logic [7:0]  OFF_BYTE_TEST   = 8'h64;
  localparam logic [7:0]  OFF_LEVELS      = 8'h68;

  // ==========================================================================
  // Reset values, fixed pattern and writable bit masks.
  localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;
  localparam logic [31:0] ENABLE_WRITABLE = 32'h83BF_E7DF;
  localparam logic [31:0] STATUS_VALID    = 32'h83BF_E7DF;
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;
  localparam logic [31:0] LEVELS_RESET    = 32'h4800_0000;
  localparam logic [31:0] LEVELS_WRITABLE = 32'hFFFF_00FF;

  // ==========================================================================
  // Field positions.
  localparam int          TX_DATA_LVL_LSB = 24;
  localparam int          TX_STS_LVL_LSB  = 16;
  localparam int          RX_STS_LVL_LSB  = 0;
  localparam int          LEVEL_WIDTH     = 8;
  localparam int          BLOCK_LOG2      = 6;
  localparam int          BIT_SPACE_AVAIL = 9;
  localparam int          BIT_TX_STS_LVL  = 7;
  localparam int          BIT_RX_STS_LVL  = 3;

  // ==========================================================================
  // Power states.
  typedef enum logic {PWR_AWAKE, PWR_ASLEEP} imfl_power_t;

endpackage

// [shared/imfl_status_if.sv]
// Connection between the register logic and the interrupt status latch.
`timescale 1ns/100ps
interface imfl_status_if;
  logic [31:0] events;
  logic [31:0] clearBits;
  logic [31:0] status;

  modport latch (input events, input clearBits, output status);
  modport ctrl  (output events, output clearBits, input status);
endinterface

// [rtl/imfl_status_latch.sv]
// Sticky interrupt status bits with write-one-to-clear.
`timescale 1ns/100ps
module imfl_status_latch (
  // Clock and reset.
  input  wire logic      ref_clk,
  input  wire logic      reset,
  // Status connection.
  imfl_status_if.latch   stsIf
);

  // ==========================================================================
  // Per-bit latches; a set in the same cycle as a clear wins.
  logic [31:0] status_r;
  wire  [31:0] status_nxt;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (imfl_pkg::STATUS_VALID[i]) begin : g_live
        assign status_nxt[i] = stsIf.events[i] | (status_r[i] & ~stsIf.clearBits[i]); // [RULE2] [RULE12]
      end else begin : g_rsvd
        assign status_nxt[i] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r <= 32'h0000_0000;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign stsIf.status = status_r;

  // ==========================================================================
  // Checks.
  property p_set_wins;
    @(posedge ref_clk) disable iff (reset)
    (stsIf.events[imfl_pkg::BIT_RX_STS_LVL] && stsIf.clearBits[imfl_pkg::BIT_RX_STS_LVL])
      |=> stsIf.status[imfl_pkg::BIT_RX_STS_LVL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Status set lost to a clear."); // [RULE12]

  property p_clear_one;
    @(posedge ref_clk) disable iff (reset)
    (stsIf.clearBits[0] && !stsIf.events[0]) |=> !stsIf.status[0];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("Write of one did not clear status."); // [RULE12]

endmodule

// [rtl/imfl_top.sv]
// Interrupt enable mask, byte order test and queue level threshold registers.
`timescale 1ns/100ps

// What this block does
// [RULE1] A 32-bit enable mask admits each set source onto the interrupt request.
// [RULE2] Status bits keep latching from sources whatever the mask says.
// [RULE3] Mask bits 31, 25, 24, 23 live; bits 30:26 and 22 read zero.
// [RULE4] Mask bits 21, 20, 19, 18 and 17 are live enables.
// [RULE5] Mask bits 16, 15, 14, 13 live; bits 12:11 read zero.
// [RULE6] Mask bits 10, 9, 8 and 7 are live enables.
// [RULE7] Mask bits 6, 4, 3, 2:0 live; bit 5 reserved; all reset to zero.
// [RULE8] A read-only test register always returns 8765_4321h.
// [RULE9] Transmit space event fires while free space exceeds level times 64 bytes.
// [RULE10] Transmit status level event fires while occupancy exceeds its level.
// [RULE11] Receive status level event fires while occupancy exceeds its level.
// [RULE12] Writing one clears a status bit; writing zero leaves it.
// [RULE13] Only a write to the test register wakes the device from low power.
// [RULE14] Interrupt request is registered: high one clock after status AND mask is nonzero, low one clock after it is zero.
module imfl_top #(
  parameter int FREE_WIDTH = 16
) (
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Register port.
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [31:0]           regWdata,
  output logic      [31:0]           regRdata,
  output logic                       regRdataValid,
  // Interrupt sources and queue levels.
  input  wire logic [31:0]           srcEvents,
  input  wire logic [FREE_WIDTH-1:0] txDataFreeBytes,
  input  wire logic [7:0]            txStatusUsedWords,
  input  wire logic [7:0]            rxStatusUsedWords,
  // Power control.
  input  wire logic                  enterLowPower,
  output logic                       deviceAsleep,
  // Interrupt request.
  output logic                       irqOut
);

  // ==========================================================================
  // Address decode.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic wrEnable;
  logic wrStatus;
  logic wrLevels;
  logic wrByteTest;

  assign wrEnable   = regWrite && hit(regAddr, imfl_pkg::OFF_ENABLE);
  assign wrStatus   = regWrite && hit(regAddr, imfl_pkg::OFF_STATUS);
  assign wrLevels   = regWrite && hit(regAddr, imfl_pkg::OFF_LEVELS);
  assign wrByteTest = regWrite && hit(regAddr, imfl_pkg::OFF_BYTE_TEST);

  // ==========================================================================
  // Enable mask register.
  logic [31:0] enable_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable_r <= imfl_pkg::ENABLE_RESET; // [RULE7]
    end else if (wrEnable) begin
      enable_r <= regWdata & imfl_pkg::ENABLE_WRITABLE; // [RULE1] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
    end
  end

  // ==========================================================================
  // Queue level threshold register.
  logic [31:0] levels_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      levels_r <= imfl_pkg::LEVELS_RESET; // [RULE9] [RULE10] [RULE11]
    end else if (wrLevels) begin
      levels_r <= regWdata & imfl_pkg::LEVELS_WRITABLE; // [RULE11]
    end
  end

  logic [7:0] txDataLevel;
  logic [7:0] txStsLevel;
  logic [7:0] rxStsLevel;

  assign txDataLevel = levels_r[imfl_pkg::TX_DATA_LVL_LSB +: imfl_pkg::LEVEL_WIDTH];
  assign txStsLevel  = levels_r[imfl_pkg::TX_STS_LVL_LSB +: imfl_pkg::LEVEL_WIDTH];
  assign rxStsLevel  = levels_r[imfl_pkg::RX_STS_LVL_LSB +: imfl_pkg::LEVEL_WIDTH];

  // ==========================================================================
  // Level comparisons.
  localparam int CMP_WIDTH = (FREE_WIDTH > 14) ? FREE_WIDTH : 14;

  logic [CMP_WIDTH-1:0] txSpaceBytes;
  logic [CMP_WIDTH-1:0] txLevelBytes;
  logic                 spaceEvent;
  logic                 txStsEvent;
  logic                 rxStsEvent;

  assign txSpaceBytes = CMP_WIDTH'(txDataFreeBytes);
  assign txLevelBytes = CMP_WIDTH'({txDataLevel, {imfl_pkg::BLOCK_LOG2{1'b0}}});
  assign spaceEvent   = txSpaceBytes > txLevelBytes;  // [RULE9]
  assign txStsEvent   = txStatusUsedWords > txStsLevel; // [RULE10]
  assign rxStsEvent   = rxStatusUsedWords > rxStsLevel; // [RULE11]

  // ==========================================================================
  // Status latch.
  imfl_status_if stsIf ();

  logic [31:0] levelEvents;

  always_comb begin
    levelEvents = 32'h0000_0000;
    levelEvents[imfl_pkg::BIT_SPACE_AVAIL] = spaceEvent;
    levelEvents[imfl_pkg::BIT_TX_STS_LVL]  = txStsEvent;
    levelEvents[imfl_pkg::BIT_RX_STS_LVL]  = rxStsEvent;
  end

  assign stsIf.events    = srcEvents | levelEvents; // [RULE2]
  assign stsIf.clearBits = wrStatus ? regWdata : 32'h0000_0000; // [RULE12]

  imfl_status_latch u_latch (
    .ref_clk (ref_clk),
    .reset   (reset),
    .stsIf   (stsIf.latch)
  );

  // ==========================================================================
  // Interrupt request.
  logic irq_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stsIf.status & enable_r); // [RULE14] [RULE1]
    end
  end

  assign irqOut = irq_r;

  // ==========================================================================
  // Power state; only a test register write wakes the device.
  imfl_pkg::imfl_power_t power_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_r <= imfl_pkg::PWR_AWAKE;
    end else begin
      unique case (power_r)
        imfl_pkg::PWR_AWAKE: begin
          if (enterLowPower) begin
            power_r <= imfl_pkg::PWR_ASLEEP;
          end
        end
        imfl_pkg::PWR_ASLEEP: begin
          if (wrByteTest) begin
            power_r <= imfl_pkg::PWR_AWAKE; // [RULE13]
          end
        end
      endcase
    end
  end

  assign deviceAsleep = (power_r == imfl_pkg::PWR_ASLEEP);

  // ==========================================================================
  // Read data.
  logic [31:0] rdata_r;
  logic        rvalid_r;
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (hit(regAddr, imfl_pkg::OFF_ENABLE)) begin
      rdMux = enable_r;
    end else if (hit(regAddr, imfl_pkg::OFF_STATUS)) begin
      rdMux = stsIf.status;
    end else if (hit(regAddr, imfl_pkg::OFF_BYTE_TEST)) begin
      rdMux = imfl_pkg::BYTE_TEST_VALUE; // [RULE8]
    end else if (hit(regAddr, imfl_pkg::OFF_LEVELS)) begin
      rdMux = levels_r;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= regRead;
      if (regRead) begin
        rdata_r <= rdMux;
      end
    end
  end

  assign regRdata      = rdata_r;
  assign regRdataValid = rvalid_r;

  // ==========================================================================
  // Checks.
  property p_irq_tracks;
    @(posedge ref_clk) disable iff (reset)
    ##1 (irqOut == |($past(stsIf.status) & $past(enable_r)));
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("Interrupt does not follow status and mask."); // [RULE14]

  property p_masked_quiet;
    @(posedge ref_clk) disable iff (reset)
    (enable_r == 32'h0000_0000) [*2] |-> !irqOut;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("Interrupt raised with all sources masked."); // [RULE1]

  property p_status_unmasked;
    @(posedge ref_clk) disable iff (reset)
    (srcEvents[0] && !enable_r[0]) |=> stsIf.status[0];
  endproperty
  a_status_unmasked: assert property (p_status_unmasked) else $error("Masked source did not latch."); // [RULE2]

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset)
    (enable_r & ~imfl_pkg::ENABLE_WRITABLE) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved mask bit set."); // [RULE3] [RULE5] [RULE7]

  property p_enable_write;
    @(posedge ref_clk) disable iff (reset)
    wrEnable |=> (enable_r[31] == $past(regWdata[31])) && (enable_r[6] == $past(regWdata[6]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("Mask write not stored."); // [RULE3] [RULE7]

  property p_byte_test;
    @(posedge ref_clk) disable iff (reset)
    (regRead && hit(regAddr, imfl_pkg::OFF_BYTE_TEST)) |=> regRdataValid && (regRdata == 32'h8765_4321);
  endproperty
  a_byte_test: assert property (p_byte_test) else $error("Test pattern read wrong."); // [RULE8]

  property p_space_level;
    @(posedge ref_clk) disable iff (reset)
    (CMP_WIDTH'(txDataFreeBytes) > CMP_WIDTH'({txDataLevel, 6'h00}))
      |=> stsIf.status[imfl_pkg::BIT_SPACE_AVAIL];
  endproperty
  a_space_level: assert property (p_space_level) else $error("Space available status not raised."); // [RULE9]

  property p_tx_sts_level;
    @(posedge ref_clk) disable iff (reset)
    (txStatusUsedWords > levels_r[23:16]) |=> stsIf.status[imfl_pkg::BIT_TX_STS_LVL];
  endproperty
  a_tx_sts_level: assert property (p_tx_sts_level) else $error("Transmit status level not raised."); // [RULE10]

  property p_rx_sts_level;
    @(posedge ref_clk) disable iff (reset)
    (rxStatusUsedWords > levels_r[7:0]) |=> stsIf.status[imfl_pkg::BIT_RX_STS_LVL];
  endproperty
  a_rx_sts_level: assert property (p_rx_sts_level) else $error("Receive status level not raised."); // [RULE11]

  property p_wake_only_test;
    @(posedge ref_clk) disable iff (reset)
    (deviceAsleep && !wrByteTest) |=> deviceAsleep;
  endproperty
  a_wake_only_test: assert property (p_wake_only_test) else $error("Woke without test register write."); // [RULE13]

  property p_wake_on_test;
    @(posedge ref_clk) disable iff (reset)
    (deviceAsleep && wrByteTest) |=> !deviceAsleep;
  endproperty
  a_wake_on_test: assert property (p_wake_on_test) else $error("Test register write did not wake."); // [RULE13]

endmodule

// [tb/imfl_host_model.sv]
// Host processor model that drives the register port of the block.
`timescale 1ns/100ps
module imfl_host_model (
  // Clock.
  input  wire logic        ref_clk,
  // Register port.
  output logic      [7:0]  regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [31:0] regWdata,
  input  wire logic [31:0] regRdata,
  input  wire logic        regRdataValid
);
  initial begin
    regAddr  = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 32'h0000_0000;
  end

  // ==========================================================================
  // Write cycle: one strobe cycle, then address and data stop showing their last value.
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(negedge ref_clk);
    regAddr  = addr;
    regWdata = data;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr  = ~addr;
    regWdata = ~data;
  endtask

  // ==========================================================================
  // Read cycle: data and valid are taken one edge after the request edge.
  task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic ok);
    @(negedge ref_clk);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~addr;
    ok      = regRdataValid;
    data    = regRdata;
  endtask
endmodule

// [tb/tb_irq_mask_fifo_level_irq.sv]
// Self-checking testbench for the interrupt mask and queue level block.
`timescale 1ns/100ps
module tb_irq_mask_fifo_level_irq;
  logic        ref_clk;
  logic        reset;
  logic [7:0]  regAddr;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic        regRdataValid;
  logic [31:0] srcEvents;
  logic [15:0] txDataFreeBytes;
  logic [7:0]  txStatusUsedWords;
  logic [7:0]  rxStatusUsedWords;
  logic        enterLowPower;
  logic        deviceAsleep;
  logic        irqOut;
  logic [31:0] rdVal;
  logic        rdOk;
  int          miscompares;
  int          nTests;

  always #2 ref_clk = ~ref_clk;

  imfl_top #(.FREE_WIDTH(16)) imfl_top_i (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regRdataValid(regRdataValid), .srcEvents(srcEvents),
    .txDataFreeBytes(txDataFreeBytes), .txStatusUsedWords(txStatusUsedWords),
    .rxStatusUsedWords(rxStatusUsedWords), .enterLowPower(enterLowPower),
    .deviceAsleep(deviceAsleep), .irqOut(irqOut)
  );

  imfl_host_model imfl_host_model_i (
    .ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regRdataValid(regRdataValid)
  );

  // ==========================================================================
  // Verdict, comparison and source pulse tasks.
  task automatic finalReport();
    if (miscompares == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdChk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    imfl_host_model_i.rd(addr, rdVal, rdOk);
    chk({name, " valid"}, 32'h0000_0001, {31'h0000_0000, rdOk});
    chk(name, exp, rdVal);
  endtask

  task automatic pulse(input logic [31:0] bits);
    @(negedge ref_clk);
    srcEvents = bits;
    @(negedge ref_clk);
    srcEvents = 32'h0000_0000;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    srcEvents = 32'h0000_0000;
    txDataFreeBytes = 16'h0000;
    txStatusUsedWords = 8'h00;
    rxStatusUsedWords = 8'h00;
    enterLowPower = 1'b0;
    miscompares = 0;
    nTests = 0;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    rdChk("enable reset", imfl_pkg::OFF_ENABLE, 32'h0000_0000);
    rdChk("byte test", imfl_pkg::OFF_BYTE_TEST, 32'h8765_4321);
    rdChk("levels reset", imfl_pkg::OFF_LEVELS, 32'h4800_0000);
    rdChk("unmapped", 8'h60, 32'h0000_0000);
    imfl_host_model_i.wr(imfl_pkg::OFF_ENABLE, 32'hFFFF_FFFF);
    rdChk("enable bits", imfl_pkg::OFF_ENABLE, 32'h83BF_E7DF);
    imfl_host_model_i.wr(imfl_pkg::OFF_ENABLE, 32'h0000_0000);
    imfl_host_model_i.wr(imfl_pkg::OFF_BYTE_TEST, 32'h0000_0000);
    rdChk("byte test kept", imfl_pkg::OFF_BYTE_TEST, 32'h8765_4321);
    imfl_host_model_i.wr(imfl_pkg::OFF_LEVELS, 32'hFFFF_FFFF);
    rdChk("levels bits", imfl_pkg::OFF_LEVELS, 32'hFFFF_00FF);
    pulse(32'hFFFF_FFFF);
    repeat (2) @(negedge ref_clk);
    rdChk("masked status", imfl_pkg::OFF_STATUS, 32'h83BF_E7DF);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irqOut});
    for (int i = 0; i < 32; i++) begin
      imfl_host_model_i.wr(imfl_pkg::OFF_ENABLE, 32'h0000_0001 << i);
      repeat (2) @(negedge ref_clk);
      chk("irq per bit", {31'h0000_0000, imfl_pkg::ENABLE_WRITABLE[i]}, {31'h0000_0000, irqOut});
    end
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'h0000_0000);
    rdChk("zero write", imfl_pkg::OFF_STATUS, 32'h83BF_E7DF);
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'h7FFF_FFFF);
    rdChk("partial clear", imfl_pkg::OFF_STATUS, 32'h8000_0000);
    chk("irq held", 32'h0000_0001, {31'h0000_0000, irqOut});
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'h8000_0000);
    repeat (2) @(negedge ref_clk);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irqOut});
    imfl_host_model_i.wr(imfl_pkg::OFF_LEVELS, 32'h0203_0005);
    txDataFreeBytes = 16'h0080;
    txStatusUsedWords = 8'h03;
    rxStatusUsedWords = 8'h05;
    repeat (2) @(negedge ref_clk);
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rdChk("level equal", imfl_pkg::OFF_STATUS, 32'h0000_0000);
    txDataFreeBytes = 16'h0081;
    txStatusUsedWords = 8'h04;
    rxStatusUsedWords = 8'h06;
    repeat (2) @(negedge ref_clk);
    rdChk("level above", imfl_pkg::OFF_STATUS, 32'h0000_0288);
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rdChk("set wins", imfl_pkg::OFF_STATUS, 32'h0000_0288);
    txDataFreeBytes = 16'h0000;
    txStatusUsedWords = 8'h00;
    rxStatusUsedWords = 8'h00;
    imfl_host_model_i.wr(imfl_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    @(negedge ref_clk);
    enterLowPower = 1'b1;
    @(negedge ref_clk);
    enterLowPower = 1'b0;
    chk("asleep", 32'h0000_0001, {31'h0000_0000, deviceAsleep});
    pulse(32'h0002_0000);
    imfl_host_model_i.wr(imfl_pkg::OFF_ENABLE, 32'h0000_0000);
    rdChk("power event", imfl_pkg::OFF_STATUS, 32'h0002_0000);
    chk("still asleep", 32'h0000_0001, {31'h0000_0000, deviceAsleep});
    imfl_host_model_i.wr(imfl_pkg::OFF_BYTE_TEST, 32'h1234_5678);
    chk("awake", 32'h0000_0000, {31'h0000_0000, deviceAsleep});
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rdChk("levels after reset", imfl_pkg::OFF_LEVELS, 32'h4800_0000);
    finalReport();
  end

  // ==========================================================================
  // Hang guard.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finalReport();
  end
endmodule
